// File: irq_ctrl.sv
// Purpose: two-level interrupt controller of an 8-bit core
// Assumes: sequencer signals and peripheral set pulses are on CLK
// Notes: call request stands for two machine cycles after acknowledge
`timescale 1ns/1ps
module irq_ctrl (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// peripheral flag set pulses
	input wire logic TIMER0_OVF_SET,
	input wire logic TIMER1_OVF_SET,
	input wire logic RX_DONE_SET,
	input wire logic TX_DONE_SET,
	input wire logic TIMER2_OVF_SET,
	input wire logic TIMER2_EXT_SET,
	// external request pins, active low
	input wire logic EXT0_INPUT_PIN_N,
	input wire logic EXT1_INPUT_PIN_N,
	// instruction sequencer
	input wire logic LAST_CYCLE,
	input wire logic BLOCK_INSTR,
	input wire logic IRQ_RETURN_DONE,
	output logic CALL_REQ,
	output logic [15:0] CALL_VECTOR,
	output logic IRQ_ACK,
	output logic [1:0] IN_SERVICE,
	output logic [7:0] REQUEST_FLAGS,
	output logic MC_START
);
	import irq_ctrl_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [2:0] first_set(input logic [NSRC-1:0] v);
		logic [2:0] idx;
		idx = IDX_RST;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : first_set

	function automatic logic [NSRC-1:0] src_req(input logic [7:0] f);
		// serial and timer2 share one request each
		return {f[FL_T2OVF] | f[FL_T2EXT], f[FL_RX] | f[FL_TX],
			f[FL_T1], f[FL_EXT1], f[FL_T0], f[FL_EXT0]};
	endfunction : src_req

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [3:0] ph_r;
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic [1:0] pin_prev_r;
	logic [7:0] enable_r;
	logic [7:0] level_r;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [1:0] edge_sel_r;
	logic [NSRC-1:0] samp_r;
	logic [1:0] act_r;
	logic [1:0] act_nxt;
	logic acc_blk_r;
	logic [2:0] last_idx_r;
	logic [15:0] vec_r;
	logic irq_ack_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic mc_start_r;
	call_st_t st_r;
	call_st_t st_nxt;

	// ------------------------------------------------------------
	// machine cycle phases
	// ------------------------------------------------------------
	wire ph_end = (ph_r == PH_LAST);
	wire smp_ph = (ph_r == SAMPLE_PH);
	wire poll_ph = (ph_r == POLL_PH);

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ph_r <= PH_ZERO;
			mc_start_r <= 1'b0;
		end else begin
			ph_r <= ph_end ? PH_ZERO : ph_r + PH_ONE;
			mc_start_r <= ph_end;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pin_s1_r <= 2'h3;
			pin_s2_r <= 2'h3;
			pin_prev_r <= 2'h3;
		end else begin
			pin_s1_r <= {EXT1_INPUT_PIN_N, EXT0_INPUT_PIN_N};
			pin_s2_r <= pin_s1_r;
			if (smp_ph) begin
				pin_prev_r <= pin_s2_r;
			end
		end
	end

	// ------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------
	wire wb_req = CYC_I & STB_I;
	wire wb_done = wb_req & ack_r;
	wire wb_wr = wb_done & WE_I;
	wire hit_en = (ADR_I == OFS_ENABLE);
	wire hit_lvl = (ADR_I == OFS_LEVEL);
	wire hit_fl = (ADR_I == OFS_FLAGS);
	wire hit_st = (ADR_I == OFS_STATUS);
	wire wr_en = wb_wr & hit_en & SEL_I[0];
	wire wr_lvl = wb_wr & hit_lvl & SEL_I[0];
	wire wr_fl = wb_wr & hit_fl & SEL_I[0];
	wire wr_edge = wb_wr & hit_fl & SEL_I[1];
	wire [31:0] rd_data = hit_en ? {24'h0, enable_r} :
		hit_lvl ? {24'h0, level_r} :
		hit_fl ? {22'h0, edge_sel_r, flags_r} :
		hit_st ? {26'h0, st_r[0], last_idx_r, act_r} : 32'h0;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= wb_req & ~ack_r;
			if (wb_req & ~ack_r) begin
				dat_r <= rd_data;
			end
		end
	end

	// ------------------------------------------------------------
	// enable, level and edge select registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			enable_r <= BYTE_RST;
			level_r <= BYTE_RST;
			edge_sel_r <= EDGE_RST;
		end else begin
			if (wr_en) begin
				enable_r <= DAT_I[7:0] & ENABLE_MASK;
			end
			if (wr_lvl) begin
				level_r <= DAT_I[7:0] & LEVEL_MASK;
			end
			if (wr_edge) begin
				edge_sel_r <= DAT_I[9:8];
			end
		end
	end

	// ------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------
	// global and source enables
	wire [NSRC-1:0] pend = samp_r & enable_r[NSRC-1:0] & {NSRC{enable_r[GLOBAL_EN_BIT]}};
	wire [NSRC-1:0] hi_pend = pend & level_r[NSRC-1:0];
	wire [NSRC-1:0] lo_pend = pend & ~level_r[NSRC-1:0];
	wire hi_ok = ~act_r[LVL_HI];
	wire lo_ok = ~act_r[LVL_HI] & ~act_r[LVL_LO];
	wire take_hi = hi_ok & (|hi_pend);
	wire [NSRC-1:0] cand = take_hi ? hi_pend : (lo_ok ? lo_pend : '0);
	wire [2:0] win_idx = first_set(cand);
	// last cycle, blocking instruction, own call
	wire seq_ok = (st_r == ST_IDLE) & LAST_CYCLE & ~BLOCK_INSTR & ~acc_blk_r;
	// call's final cycle is polled too
	wire poll_ok = poll_ph & (seq_ok | (st_r == ST_CALL2));
	// decision uses only the samples taken in the previous machine cycle
	wire accept = poll_ok & (|cand);
	wire [15:0] win_vec = VEC_BASE + {10'h0, win_idx, 3'h0};

	// ------------------------------------------------------------
	// request flags
	// ------------------------------------------------------------
	wire [1:0] pin_low = ~pin_s2_r;
	wire [1:0] fall = {2{smp_ph}} & edge_sel_r & pin_prev_r & pin_low;
	wire [1:0] lvl_set = {2{smp_ph}} & ~edge_sel_r & pin_low;
	wire [1:0] lvl_clr = {2{smp_ph}} & ~edge_sel_r & pin_s2_r;
	wire [1:0] ext_set = fall | lvl_set;
	wire [NSRC-1:0] win_hot = accept ? (NSRC'(1) << win_idx) : '0;
	wire [7:0] hw_set = {TIMER2_EXT_SET, TIMER2_OVF_SET, TX_DONE_SET, RX_DONE_SET,
		TIMER1_OVF_SET, ext_set[1], TIMER0_OVF_SET, ext_set[0]};
	// ext cleared by acknowledge only in edge mode, timer0 and timer1 always
	wire [7:0] ack_clr = {4'h0, win_hot[FL_T1], win_hot[FL_EXT1] & edge_sel_r[1],
		win_hot[FL_T0], win_hot[FL_EXT0] & edge_sel_r[0]};
	wire [7:0] hw_clr = ack_clr | {5'h0, lvl_clr[1], 1'b0, lvl_clr[0]};

	// hardware set wins over any clear in the same cycle
	assign flags_nxt = hw_set | (wr_fl ? DAT_I[7:0] : (flags_r & ~hw_clr));

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			flags_r <= BYTE_RST;
			samp_r <= '0;
		end else begin
			flags_r <= flags_nxt;
			if (smp_ph) begin
				samp_r <= src_req(flags_nxt);
			end
		end
	end

	// ------------------------------------------------------------
	// blocking after enable or level access
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			acc_blk_r <= 1'b0;
		end else if (wb_done & (hit_en | hit_lvl)) begin
			acc_blk_r <= 1'b1;
		end else if (poll_ph) begin
			acc_blk_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// in-progress levels
	// ------------------------------------------------------------
	always_comb begin
		act_nxt = act_r;
		// return clears the highest active level
		if (IRQ_RETURN_DONE) begin
			if (act_r[LVL_HI]) begin
				act_nxt[LVL_HI] = 1'b0;
			end else begin
				act_nxt[LVL_LO] = 1'b0;
			end
		end
		if (accept) begin
			act_nxt[take_hi ? LVL_HI : LVL_LO] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// call sequence
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				if (accept) begin
					st_nxt = ST_CALL1;
				end
			end
			ST_CALL1: begin
				if (poll_ph) begin
					st_nxt = ST_CALL2;
				end
			end
			ST_CALL2: begin
				if (poll_ph) begin
					st_nxt = accept ? ST_CALL1 : ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_r <= ST_IDLE;
			act_r <= ACT_RST;
			vec_r <= VEC_RST;
			last_idx_r <= IDX_RST;
			irq_ack_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			// only the return pulse clears a level
			act_r <= act_nxt;
			irq_ack_r <= accept;
			if (accept) begin
				vec_r <= win_vec;
				last_idx_r <= win_idx;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign DAT_O = dat_r;
	assign ACK_O = ack_r;
	assign CALL_REQ = st_r[0];
	assign CALL_VECTOR = vec_r;
	assign IRQ_ACK = irq_ack_r;
	assign IN_SERVICE = act_r;
	assign REQUEST_FLAGS = flags_r;
	assign MC_START = mc_start_r;
endmodule : irq_ctrl

// File: irq_ctrl_pkg.sv
// Purpose: constants and types shared by the two-level interrupt controller
// Assumes: CLK is the oscillator, twelve periods make one machine cycle
// Notes: register offsets are byte addresses on a 32-bit Wishbone slave
package irq_ctrl_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int OSC_PERIOD_NS = 100;
	localparam int MC_OSC_PERIODS = 12;
	localparam int MC_CLKS = MC_OSC_PERIODS * OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0] PH_LAST = 4'(MC_CLKS - 1);
	localparam logic [3:0] PH_ZERO = 4'h0;
	localparam logic [3:0] PH_ONE = 4'h1;
	localparam logic [3:0] SAMPLE_PH = 4'h8;
	localparam logic [3:0] POLL_PH = 4'h5;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_LEVEL = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] ENABLE_MASK = 8'hbf;
	localparam logic [7:0] LEVEL_MASK = 8'h3f;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] EDGE_RST = 2'h0;
	localparam int GLOBAL_EN_BIT = 7;
	// ------------------------------------------------------------
	// sources in polling order, flag bits
	// ------------------------------------------------------------
	localparam int NSRC = 6;
	localparam int FL_EXT0 = 0;
	localparam int FL_T0 = 1;
	localparam int FL_EXT1 = 2;
	localparam int FL_T1 = 3;
	localparam int FL_RX = 4;
	localparam int FL_TX = 5;
	localparam int FL_T2OVF = 6;
	localparam int FL_T2EXT = 7;
	localparam int LVL_LO = 0;
	localparam int LVL_HI = 1;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_RST = 16'h0000;
	localparam logic [2:0] IDX_RST = 3'h0;
	localparam logic [1:0] ACT_RST = 2'h0;
	localparam int VEC_SHIFT = 3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALL1 = 2'b01,
		ST_CALL2 = 2'b11
	} call_st_t;
endpackage : irq_ctrl_pkg

// File: irq_ctrl_props.sv
// Purpose: port checks for irq_ctrl
// Assumes: one clock, sync reset
// Notes: bound at the foot
`timescale 1ns/1ps
module irq_ctrl_props (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// bus
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	// sequencer side
	input wire logic IRQ_RETURN_DONE,
	input wire logic CALL_REQ,
	input wire logic [15:0] CALL_VECTOR,
	input wire logic IRQ_ACK,
	input wire logic [1:0] IN_SERVICE,
	input wire logic MC_START
);
	import irq_ctrl_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// ----------
	// assertions
	// ----------
	a_bus_ack_next:
	assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack missing");
	a_bus_ack_pulse:
	assert property (ACK_O |=> !ACK_O) else $error("ack too long");
	a_mc_period:
	assert property (MC_START |-> ##12 MC_START) else $error("cycle length");
	a_call_on_ack:
	assert property ($rose(CALL_REQ) |-> IRQ_ACK) else $error("call without ack");
	a_call_two_mc:
	assert property ($rose(CALL_REQ) |-> CALL_REQ[*8] ##16 CALL_REQ) else $error("call short");
	a_vec_form:
	assert property (IRQ_ACK |-> CALL_VECTOR[2:0] == 3'h3 && CALL_VECTOR <= 16'h002b)
		else $error("bad vector");
	a_high_blocks:
	assert property (IRQ_ACK |-> !$past(IN_SERVICE[1])) else $error("high preempted");
	a_ack_marks_level:
	assert property (IRQ_ACK |=> IN_SERVICE != 2'h0) else $error("level not marked");
	a_ret_clears_high:
	assert property (IRQ_RETURN_DONE && IN_SERVICE[1] |=> !IN_SERVICE[1])
		else $error("high kept");
	a_ret_clears_low:
	assert property (IRQ_RETURN_DONE && IN_SERVICE == 2'h1 |=> !IN_SERVICE[0])
		else $error("low kept");
endmodule : irq_ctrl_props
bind irq_ctrl irq_ctrl_props u_props (.CLK, .SYS_RST, .CYC_I, .STB_I, .ACK_O,
	.IRQ_RETURN_DONE, .CALL_REQ, .CALL_VECTOR, .IRQ_ACK, .IN_SERVICE, .MC_START);

// File: irq_seq_model.sv
// Purpose: instruction sequencer stand-in
// Assumes: one-cycle instructions unless held long
// Notes: bench commands long, blocking and return
`timescale 1ns/1ps
module irq_seq_model (
	// clock
	input wire logic clk,
	// commands: bit0 long instruction, bit1 blocking one
	input wire logic [1:0] blk_cmd,
	input wire logic ret_cmd,
	// sequencer status
	output logic last_cycle = 1'b1,
	output logic block_instr = 1'b0,
	output logic ret_done = 1'b0
);
	import irq_ctrl_pkg::*;
	always @(posedge clk) begin
		last_cycle <= !blk_cmd[0];
		block_instr <= blk_cmd[1];
	end
	always @(posedge clk) begin
		ret_done <= ret_cmd;
	end
endmodule : irq_seq_model

// File: tb.sv
// Purpose: self-checking bench for irq_ctrl
// Assumes: sequencer model, bench drives pins
// Notes: acks awaited five machine cycles
`timescale 1ns/1ps
module tb;
	import irq_ctrl_pkg::*;
	logic clk, rst, cyc, stb, we, ack, e0_n, e1_n, ret_c, last_c, blk_i, ret_d;
	logic call_req, irq_ack, mc_start;
	logic [1:0] blk_c, in_svc;
	logic [3:0] sel;
	logic [7:0] adr, set_p, flags, ef;
	logic [15:0] vec, v;
	logic [31:0] wdat, rdat, r;
	int error_cnt = 0;
	int checks_done = 0;
	int n_wait;
	irq_ctrl u_dut (.CLK(clk), .SYS_RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
		.TIMER0_OVF_SET(set_p[1]), .TIMER1_OVF_SET(set_p[3]), .RX_DONE_SET(set_p[4]),
		.TX_DONE_SET(set_p[5]), .TIMER2_OVF_SET(set_p[6]), .TIMER2_EXT_SET(set_p[7]),
		.EXT0_INPUT_PIN_N(e0_n), .EXT1_INPUT_PIN_N(e1_n), .LAST_CYCLE(last_c),
		.BLOCK_INSTR(blk_i), .IRQ_RETURN_DONE(ret_d), .CALL_REQ(call_req),
		.CALL_VECTOR(vec), .IRQ_ACK(irq_ack), .IN_SERVICE(in_svc),
		.REQUEST_FLAGS(flags), .MC_START(mc_start));
	irq_seq_model u_seq (.clk(clk), .blk_cmd(blk_c), .ret_cmd(ret_c),
		.last_cycle(last_c), .block_instr(blk_i), .ret_done(ret_d));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// -----
	// tasks
	// -----
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		chk("ack", 1'b1, ack);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hf);
		chk("register", e, r);
	endtask : rd
	task automatic setp(input logic [7:0] m);
		set_p <= m;
		@(posedge clk);
		set_p <= 8'h00;
		@(posedge clk);
	endtask : setp
	task automatic want(input logic [15:0] e);
		v = 16'hffff;
		n_wait = 0;
		while (n_wait < 60 && v === 16'hffff) begin
			@(posedge clk);
			n_wait++;
			if (irq_ack === 1'b1) v = vec;
		end
		chk("vector", {16'h0, e}, {16'h0, v});
	endtask : want
	task automatic irq_ret();
		ret_c <= 1'b1;
		@(posedge clk);
		ret_c <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : irq_ret
	// -----
	// tests
	// -----
	initial begin
		rst = 1'b1;
		{cyc, stb, we, ret_c, e0_n, e1_n} = 6'h03;
		{adr, set_p, sel, blk_c} = 22'h0;
		wdat = 32'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0);
		wb(1'b1, OFS_ENABLE, 32'hff, 4'h1);
		rd(OFS_ENABLE, 32'hbf);
		wb(1'b1, OFS_LEVEL, 32'hff, 4'h1);
		rd(OFS_LEVEL, 32'h3f);
		rd(8'h10, 32'h0);
		wb(1'b1, OFS_LEVEL, 32'h0, 4'h1);
		wb(1'b1, OFS_ENABLE, 32'h3f, 4'h1);
		setp(8'h02);
		want(16'hffff);
		chk("flags", 8'h02, flags);
		wb(1'b1, OFS_ENABLE, 32'h82, 4'h1);
		want(16'h000b);
		repeat (30) @(posedge clk);
		chk("flags", 8'h00, flags);
		chk("level", 2'h1, in_svc);
		irq_ret();
		chk("level", 2'h0, in_svc);
		wb(1'b1, OFS_ENABLE, 32'hbf, 4'h1);
		wb(1'b1, OFS_FLAGS, 32'h3ff, 4'h3);
		ef = 8'hff;
		for (int k = 0; k < 6; k++) begin
			want(16'h0003 + 16'(8 * k));
			repeat (30) @(posedge clk);
			if (k < 4) ef[k] = 1'b0;
			chk("flags", ef, flags);
			if (k > 3) begin
				ef = (k == 4) ? 8'hc0 : 8'h00;
				wb(1'b1, OFS_FLAGS, {24'h0, ef}, 4'h1);
			end
			irq_ret();
		end
		wb(1'b1, OFS_ENABLE, 32'h9a, 4'h1);
		wb(1'b1, OFS_LEVEL, 32'h18, 4'h1);
		setp(8'h0a);
		want(16'h001b);
		setp(8'h10);
		want(16'hffff);
		irq_ret();
		want(16'h0023);
		wb(1'b1, OFS_FLAGS, 32'h02, 4'h1);
		irq_ret();
		want(16'h000b);
		setp(8'h08);
		want(16'h001b);
		repeat (30) @(posedge clk);
		chk("level", 2'h3, in_svc);
		irq_ret();
		chk("level", 2'h1, in_svc);
		irq_ret();
		blk_c <= 2'h1;
		setp(8'h02);
		want(16'hffff);
		blk_c <= 2'h2;
		want(16'hffff);
		blk_c <= 2'h0;
		want(16'h000b);
		irq_ret();
		blk_c <= 2'h1;
		setp(8'h02);
		wb(1'b1, OFS_FLAGS, 32'h0, 4'h1);
		blk_c <= 2'h0;
		want(16'hffff);
		wb(1'b1, OFS_ENABLE, 32'h85, 4'h1);
		wb(1'b1, OFS_FLAGS, 32'h100, 4'h2);
		repeat (24) @(posedge clk);
		e0_n <= 1'b0;
		want(16'h0003);
		repeat (30) @(posedge clk);
		chk("flags", 8'h00, flags);
		irq_ret();
		e1_n <= 1'b0;
		want(16'h0013);
		repeat (30) @(posedge clk);
		chk("flags", 8'h04, flags);
		e1_n <= 1'b1;
		repeat (30) @(posedge clk);
		chk("flags", 8'h00, flags);
		irq_ret();
		want(16'hffff);
		wb(1'b1, OFS_ENABLE, 32'hb0, 4'h1);
		for (int i = 4; i < 8; i++) begin
			setp(8'h01 << i);
			want(i < 6 ? 16'h0023 : 16'h002b);
			chk("latency", 32'h1, {31'h0, n_wait > 0 && n_wait <= 3 * MC_CLKS});
			wb(1'b1, OFS_FLAGS, 32'h0, 4'h1);
			irq_ret();
		end
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule : tb
